// >>> shared/readout_pkg.sv
// constants and types for the analog input readout block
//
// Summary of operation
// - input span maps to codes 80d2 through 7f2e, symmetric about zero.
// - negative inputs are two's-complement; sample msb is the sign.
// - sample sits in bits 31:16; inputs 0, 1, 4, 5 group one, 2, 3, 6, 7 group two.
// - inputs 0, 1, 4, 5 convert at each phase clock rising edge.
// - inputs 2, 3, 6, 7 convert at each phase clock falling edge.
// - control, strobe, header count, delay reset to capture values.
// - no sign conversion, io control 0, polarity 0, direction 0000ffff.
// - input n filter cut-off from output bits 2n+1:2n, 00 is 3.2 kHz.
// - filter fields fill output bits 15:0; input 7 uses bits 15:14.
// - register bank index comes from a 16-position rotary switch.
package readout_pkg;
  localparam int ADDR_W   = 8;
  localparam int DATA_W   = 32;
  localparam int NUM_IN   = 8;
  localparam int LANES    = 4;
  localparam int SMP_W    = 16;
  localparam int DIV_W    = 4;
  localparam int HDR_W    = 5;
  localparam int BANK_W   = 4;
  localparam int FRAME_W  = 24;
  localparam int FIFO_DEP = 16;

  localparam logic [15:0] CODE_MIN = 16'h80d2;
  localparam logic [15:0] CODE_MAX = 16'h7f2e;

  localparam logic [7:0] OFF_SAMPLE0 = 8'h00;
  localparam logic [7:0] OFF_OUT_WORD = 8'h20;
  localparam logic [7:0] OFF_DIV     = 8'h24;
  localparam logic [7:0] OFF_CTRL    = 8'h28;
  localparam logic [7:0] OFF_DELAY   = 8'h2c;
  localparam logic [7:0] OFF_HDR     = 8'h30;
  localparam logic [7:0] OFF_STROBE  = 8'h34;
  localparam logic [7:0] OFF_UTOS    = 8'h38;
  localparam logic [7:0] OFF_GCTL    = 8'h3c;
  localparam logic [7:0] OFF_DIR     = 8'h40;
  localparam logic [7:0] OFF_POL     = 8'h44;
  localparam logic [7:0] OFF_STATUS  = 8'h48;

  localparam logic [DIV_W-1:0]   RST_DIV    = 4'h5;
  localparam logic [31:0]        RST_CTRL   = 32'hfffffc01;
  localparam logic [HDR_W-1:0]   RST_DELAY  = 5'h00;
  localparam logic [HDR_W-1:0]   RST_HDR    = 5'h01;
  localparam logic [FRAME_W-1:0] RST_STROBE = 24'hfffffc;
  localparam logic [31:0]        RST_DIR    = 32'h0000ffff;
  localparam logic [31:0]        RST_ZERO   = 32'h00000000;

  localparam int CTRL_EN_BIT = 0;
  localparam int ST_BANK_LSB = 8;
  localparam int ST_LVL_LSB  = 12;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_SHIFT = 2'b01,
    RX_DONE  = 2'b11
  } rx_state_t;
endpackage

// >>> src/sample_fifo.sv
// sample fifo between conversion results and readout registers
`timescale 1ns/1ps
module sample_fifo #(
  parameter int WIDTH = 19,
  parameter int DEPTH = readout_pkg::FIFO_DEP
) (
  input  wire logic                   clock,
  input  wire logic                   rst,
  input  wire logic                   in_valid,
  output logic                        in_ready,
  input  wire logic [WIDTH-1:0]       in_data,
  output logic                        out_valid,
  input  wire logic                   out_ready,
  output logic [WIDTH-1:0]            out_data,
  output logic [$clog2(DEPTH):0]      level
);
  import readout_pkg::*;
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW:0]      wr_q;
  logic [PW:0]      rd_q;
  wire push = in_valid && in_ready;
  wire pop  = out_valid && out_ready;
  assign level     = wr_q - rd_q;
  assign in_ready  = level != (PW+1)'(DEPTH);
  assign out_valid = level != '0;
  assign out_data  = mem[rd_q[PW-1:0]];

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_q[PW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= wr_q + (PW+1)'(push);
      rd_q <= rd_q + (PW+1)'(pop);
    end
  end
endmodule // sample_fifo

// >>> src/serial_capture.sv
// serial frame capture from one group of converters
`timescale 1ns/1ps
module serial_capture #(
  parameter int LANES = readout_pkg::LANES,
  parameter int BITS  = readout_pkg::FRAME_W
) (
  input  wire logic                          clock,
  input  wire logic                          rst,
  input  wire logic                          start,
  input  wire logic [readout_pkg::DIV_W-1:0] divider,
  input  wire logic [readout_pkg::HDR_W-1:0] first_bit,
  input  wire logic [BITS-1:0]               pattern,
  input  wire logic [LANES-1:0]              sdi,
  output logic                               sclk,
  output logic                               strobe,
  output logic                               busy,
  output logic                               done,
  output logic [LANES*16-1:0]                code
);
  import readout_pkg::*;
  rx_state_t        state_q;
  logic [DIV_W-1:0] div_q;
  logic [HDR_W-1:0] bit_q;
  logic             sclk_q;
  logic [LANES*16-1:0] code_q;

  wire [DIV_W-1:0] div_last = (divider == '0) ? '0 : divider - 1'b1;
  wire tick      = div_q >= div_last;
  wire rise_tick = (state_q == RX_SHIFT) && tick && !sclk_q;
  wire last_bit  = bit_q == HDR_W'(BITS-1);
  wire in_word   = (bit_q >= first_bit) &&
                   ({1'b0, bit_q} < {1'b0, first_bit} + 6'd16);

  assign busy   = state_q != RX_IDLE;
  assign done   = state_q == RX_DONE;
  assign sclk   = sclk_q;
  assign code   = code_q;
  assign strobe = (state_q == RX_SHIFT) &&
                  pattern[HDR_W'(BITS-1) - bit_q];

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q <= RX_IDLE;
      div_q   <= '0;
      bit_q   <= '0;
      sclk_q  <= 1'b0;
    end else begin
      case (state_q)
        RX_IDLE: begin
          div_q  <= '0;
          bit_q  <= '0;
          sclk_q <= 1'b0;
          if (start) begin
            state_q <= RX_SHIFT;
          end
        end
        RX_SHIFT: begin
          div_q <= tick ? '0 : div_q + 1'b1;
          if (tick) begin
            sclk_q <= !sclk_q;
          end
          if (rise_tick) begin
            bit_q <= bit_q + 1'b1;
            if (last_bit) begin
              state_q <= RX_DONE;
            end
          end
        end
        default: begin
          sclk_q  <= 1'b0;
          state_q <= RX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      code_q <= '0;
    end else if (rise_tick && in_word) begin
      for (int l = 0; l < LANES; l++) begin
        code_q[l*16 +: 16] <= {code_q[l*16 +: 15], sdi[l]};
      end
    end
  end

  frame_bound_a: assert property (@(posedge clock) disable iff (rst)
    (state_q == RX_IDLE) && start && (divider == 4'h5)
      |-> ##236 done)
    else $error("capture frame length wrong for divider 5");
endmodule // serial_capture

// >>> src/analog_input_readout.sv
// analog input readout: conversion timing, samples, filter outputs
`timescale 1ns/1ps
module analog_input_readout (
  input  wire logic                           clock,
  input  wire logic                           rst,
  input  wire logic [readout_pkg::ADDR_W-1:0] addr,
  input  wire logic [readout_pkg::DATA_W-1:0] wdata,
  input  wire logic                           wr_stb,
  input  wire logic                           rd_stb,
  output logic [readout_pkg::DATA_W-1:0]      rdata,
  input  wire logic [readout_pkg::BANK_W-1:0] bus_bank,
  input  wire logic [readout_pkg::BANK_W-1:0] bank_switch,
  input  wire logic                           phase_clk,
  input  wire logic [readout_pkg::LANES-1:0]  sdi_rise,
  input  wire logic [readout_pkg::LANES-1:0]  sdi_fall,
  output logic                                sclk_rise,
  output logic                                sclk_fall,
  output logic                                strobe_rise,
  output logic                                strobe_fall,
  output logic [15:0]                         filter_sel,
  output logic [31:0]                         gpio_out,
  output logic [31:0]                         gpio_oe
);
  import readout_pkg::*;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [15:0] to_sample(input logic [15:0] raw,
                                            input logic uts);
    logic signed [15:0] s;
    s = uts ? {~raw[15], raw[14:0]} : raw;
    if (s < $signed(CODE_MIN)) begin
      to_sample = CODE_MIN;
    end else if (s > $signed(CODE_MAX)) begin
      to_sample = CODE_MAX;
    end else begin
      to_sample = s;
    end
  endfunction

  // lane l of group g (0 rising, 1 falling) to input number
  function automatic logic [2:0] lane_input(input int g, input int l);
    logic [1:0] lb;
    lb = 2'(l);
    lane_input = {lb[1], 1'(g), lb[0]};
  endfunction

  function automatic logic [2:0] first_set(input logic [7:0] v);
    first_set = '0;
    for (int i = NUM_IN - 1; i >= 0; i--) begin
      if (v[i]) begin
        first_set = 3'(i);
      end
    end
  endfunction

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [31:0]          out_word_q;
  logic [DIV_W-1:0]     div_q;
  logic [31:0]          ctrl_q;
  logic [HDR_W-1:0]     delay_q;
  logic [HDR_W-1:0]     hdr_q;
  logic [FRAME_W-1:0]   strobe_q;
  logic                 uts_q;
  logic [31:0]          gctl_q;
  logic [31:0]          dir_q;
  logic [31:0]          pol_q;
  logic [7:0]           overrun_q;
  logic [BANK_W-1:0]    bank_q;
  logic                 strap_taken_q;
  logic [31:0]          rdata_q;
  logic                 phase_q;
  logic [15:0]          filter_q;
  logic [31:0]          gpio_out_q;
  logic [31:0]          gpio_oe_q;
  logic [NUM_IN-1:0][15:0] sample_q;
  logic [NUM_IN-1:0]    pend_q;
  logic [NUM_IN-1:0][15:0] pend_code_q;

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  wire       hit      = bus_bank == bank_q;
  wire       wr_hit   = wr_stb && hit;
  wire       rd_hit   = rd_stb && hit;
  wire       is_smp   = (addr[7:5] == 3'b000) && (addr[1:0] == 2'b00);
  wire [2:0] smp_idx  = addr[4:2];
  wire       wr_out   = wr_hit && (addr == OFF_OUT_WORD);
  wire       wr_div   = wr_hit && (addr == OFF_DIV);
  wire       wr_ctrl  = wr_hit && (addr == OFF_CTRL);
  wire       wr_delay = wr_hit && (addr == OFF_DELAY);
  wire       wr_hdr   = wr_hit && (addr == OFF_HDR);
  wire       wr_strb  = wr_hit && (addr == OFF_STROBE);
  wire       wr_uts   = wr_hit && (addr == OFF_UTOS);
  wire       wr_gctl  = wr_hit && (addr == OFF_GCTL);
  wire       wr_dir   = wr_hit && (addr == OFF_DIR);
  wire       wr_pol   = wr_hit && (addr == OFF_POL);
  wire       wr_stat  = wr_hit && (addr == OFF_STATUS);
  wire [15:0] rd_smp  = sample_q[smp_idx];

  // ---------------------------------------------------------------
  // conversion timing
  // ---------------------------------------------------------------
  wire conv_en    = ctrl_q[CTRL_EN_BIT];
  // edges ignored until phase_q has sampled the pin once after reset
  wire phase_rise = strap_taken_q && phase_clk && !phase_q;
  wire phase_fall = strap_taken_q && !phase_clk && phase_q;
  wire [1:0]  grp_busy;
  wire [1:0]  grp_done;
  wire [63:0] grp_code [2];
  wire [HDR_W-1:0] first_bit = hdr_q + delay_q;

  serial_capture #(.LANES(LANES), .BITS(FRAME_W)) rise_cap (
    .clock    (clock),
    .rst      (rst),
    .start    (phase_rise && conv_en),
    .divider  (div_q),
    .first_bit(first_bit),
    .pattern  (strobe_q),
    .sdi      (sdi_rise),
    .sclk     (sclk_rise),
    .strobe   (strobe_rise),
    .busy     (grp_busy[0]),
    .done     (grp_done[0]),
    .code     (grp_code[0])
  );

  serial_capture #(.LANES(LANES), .BITS(FRAME_W)) fall_cap (
    .clock    (clock),
    .rst      (rst),
    .start    (phase_fall && conv_en),
    .divider  (div_q),
    .first_bit(first_bit),
    .pattern  (strobe_q),
    .sdi      (sdi_fall),
    .sclk     (sclk_fall),
    .strobe   (strobe_fall),
    .busy     (grp_busy[1]),
    .done     (grp_done[1]),
    .code     (grp_code[1])
  );

  // ---------------------------------------------------------------
  // pending results and fifo push
  // ---------------------------------------------------------------
  logic [NUM_IN-1:0]       pend_set;
  logic [NUM_IN-1:0][15:0] new_code;

  always_comb begin
    pend_set = '0;
    new_code = pend_code_q;
    for (int g = 0; g < 2; g++) begin
      for (int l = 0; l < LANES; l++) begin
        if (grp_done[g]) begin
          pend_set[lane_input(g, l)] = 1'b1;
          new_code[lane_input(g, l)] =
            to_sample(grp_code[g][l*16 +: 16], uts_q);
        end
      end
    end
  end

  wire [2:0]  push_idx   = first_set(pend_q);
  wire        push_valid = |pend_q;
  wire        push_ready;
  wire        push_fire  = push_valid && push_ready;
  wire [15:0] push_code  = pend_code_q[push_idx];
  wire [NUM_IN-1:0] pend_clr =
    push_fire ? (NUM_IN'(1) << push_idx) : '0;
  // a fresh sample wins over the clear of the one just pushed
  wire [NUM_IN-1:0] pend_d = (pend_q & ~pend_clr) | pend_set;
  wire [NUM_IN-1:0] lost   = pend_set & pend_q & ~pend_clr;

  // ---------------------------------------------------------------
  // fifo and readout update
  // ---------------------------------------------------------------
  wire        drain_valid;
  wire        drain_ready = !rd_stb;
  wire [18:0] drain_data;
  wire        drain_fire  = drain_valid && drain_ready;
  wire [$clog2(FIFO_DEP):0] fifo_level;

  sample_fifo #(.WIDTH(19), .DEPTH(FIFO_DEP)) fifo (
    .clock    (clock),
    .rst      (rst),
    .in_valid (push_valid),
    .in_ready (push_ready),
    .in_data  ({push_idx, push_code}),
    .out_valid(drain_valid),
    .out_ready(drain_ready),
    .out_data (drain_data),
    .level    (fifo_level)
  );

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sample_q <= '0;
    end else if (drain_fire) begin
      sample_q[drain_data[18:16]] <= drain_data[15:0];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pend_q      <= '0;
      pend_code_q <= '0;
      phase_q     <= 1'b0;
    end else begin
      pend_q      <= pend_d;
      pend_code_q <= new_code;
      phase_q     <= phase_clk;
    end
  end

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      out_word_q <= RST_ZERO;
      div_q      <= RST_DIV;
      ctrl_q     <= RST_CTRL;
      delay_q    <= RST_DELAY;
      hdr_q      <= RST_HDR;
      strobe_q   <= RST_STROBE;
      uts_q      <= 1'b0;
      gctl_q     <= RST_ZERO;
      dir_q      <= RST_DIR;
      pol_q      <= RST_ZERO;
    end else begin
      if (wr_out)   out_word_q <= wdata;
      if (wr_div)   div_q      <= wdata[DIV_W-1:0];
      if (wr_ctrl)  ctrl_q     <= wdata;
      if (wr_delay) delay_q    <= wdata[HDR_W-1:0];
      if (wr_hdr)   hdr_q      <= wdata[HDR_W-1:0];
      if (wr_strb)  strobe_q   <= wdata[FRAME_W-1:0];
      if (wr_uts)   uts_q      <= wdata[0];
      if (wr_gctl)  gctl_q     <= wdata;
      if (wr_dir)   dir_q      <= wdata;
      if (wr_pol)   pol_q      <= wdata;
    end
  end

  // overrun flags: write one to clear, a new loss wins
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      overrun_q <= '0;
    end else begin
      overrun_q <= (overrun_q & ~(wr_stat ? wdata[7:0] : 8'h00)) | lost;
    end
  end

  // switch caught once after reset release
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bank_q        <= '0;
      strap_taken_q <= 1'b0;
    end else if (!strap_taken_q) begin
      bank_q        <= bank_switch;
      strap_taken_q <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // output pins
  // ---------------------------------------------------------------
  wire [31:0] pin_val = (out_word_q ^ pol_q) & dir_q;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      filter_q   <= '0;
      gpio_out_q <= '0;
      gpio_oe_q  <= '0;
    end else begin
      filter_q   <= pin_val[15:0];
      gpio_out_q <= pin_val;
      gpio_oe_q  <= dir_q;
    end
  end

  assign filter_sel = filter_q;
  assign gpio_out   = gpio_out_q;
  assign gpio_oe    = gpio_oe_q;

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  logic [31:0] rd_val;
  always_comb begin
    rd_val = '0;
    if (is_smp) begin
      rd_val = {rd_smp, 16'h0000};
    end else begin
      case (addr)
        OFF_OUT_WORD: rd_val = out_word_q;
        OFF_DIV:      rd_val = 32'(div_q);
        OFF_CTRL:     rd_val = ctrl_q;
        OFF_DELAY:    rd_val = 32'(delay_q);
        OFF_HDR:      rd_val = 32'(hdr_q);
        OFF_STROBE:   rd_val = 32'(strobe_q);
        OFF_UTOS:     rd_val = 32'(uts_q);
        OFF_GCTL:     rd_val = gctl_q;
        OFF_DIR:      rd_val = dir_q;
        OFF_POL:      rd_val = pol_q;
        OFF_STATUS: begin
          rd_val[7:0] = overrun_q;
          rd_val[ST_BANK_LSB +: BANK_W] = bank_q;
          rd_val[ST_LVL_LSB +: 5] = fifo_level;
        end
        default:      rd_val = '0;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rd_hit ? rd_val : '0;
    end
  end

  assign rdata = rdata_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  code_range_a: assert property (@(posedge clock) disable iff (rst)
    push_fire |-> ($signed(push_code) >= $signed(CODE_MIN)) &&
                  ($signed(push_code) <= $signed(CODE_MAX)))
    else $error("sample outside symmetric code span");

  sign_kept_a: assert property (@(posedge clock) disable iff (rst)
    grp_done[0] && !uts_q |=>
      pend_q[0] && (pend_code_q[0][15] == $past(grp_code[0][15])))
    else $error("sample sign bit not kept");

  readout_word_a: assert property (@(posedge clock) disable iff (rst)
    rd_hit && is_smp |=>
      (rdata[15:0] == 16'h0000) && (rdata[31:16] == $past(rd_smp)))
    else $error("sample not in upper half of readout");

  rise_start_a: assert property (@(posedge clock) disable iff (rst)
    phase_rise && conv_en && !grp_busy[0] && !grp_busy[1]
      |=> grp_busy[0] && !grp_busy[1])
    else $error("rising edge did not start first group only");

  fall_start_a: assert property (@(posedge clock) disable iff (rst)
    phase_fall && conv_en && !grp_busy[1] && !grp_busy[0]
      |=> grp_busy[1] && !grp_busy[0])
    else $error("falling edge did not start second group only");

  div_reset_a: assert property (@(posedge clock)
    $fell(rst) |-> (div_q == 4'h5))
    else $error("divider reset value wrong");

  ctrl_reset_a: assert property (@(posedge clock)
    $fell(rst) |-> (ctrl_q == 32'hfffffc01) && (hdr_q == 5'h01) &&
                   (strobe_q == 24'hfffffc) && (delay_q == 5'h00))
    else $error("capture settings reset values wrong");

  dir_reset_a: assert property (@(posedge clock)
    $fell(rst) |-> (dir_q == 32'h0000ffff) && (pol_q == 32'h0) &&
                   (gctl_q == 32'h0) && !uts_q)
    else $error("io settings reset values wrong");

  filter_out_a: assert property (@(posedge clock) disable iff (rst)
    wr_out && (pol_q == 32'h0) && (dir_q[15:0] == 16'hffff)
      |=> ##1 filter_sel == $past(wdata[15:0], 2))
    else $error("filter select pins do not follow output word");

  bank_miss_a: assert property (@(posedge clock) disable iff (rst)
    rd_stb && !hit |=> rdata == 32'h0)
    else $error("other bank read returned data");

  sample_hold_a: assert property (@(posedge clock) disable iff (rst)
    !drain_fire |=> $stable(sample_q))
    else $error("readout changed without new sample");
endmodule // analog_input_readout

// >>> dv/converter_model.sv
// behavioural model of four converters sharing one frame clock
`timescale 1ns/1ps
module converter_model (
  input  wire logic        strobe,
  input  wire logic        sclk,
  input  wire logic [63:0] codes,
  output logic      [3:0]  sdi
);
  logic [23:0] word_q [4];
  int          cnt_q;

  initial begin
    sdi   = 4'h0;
    cnt_q = 24;
  end

  // ----------------------------------------
  // frame load: header bit, code, filler
  // ----------------------------------------
  always @(posedge strobe) begin
    for (int i = 0; i < 4; i++) begin
      word_q[i] = {1'b1, codes[i*16 +: 16], 7'h2a};
      sdi[i]    = word_q[i][23];
    end
    cnt_q = 1;
  end

  // next bit after each sample; released line toggles
  always @(posedge sclk) begin
    for (int i = 0; i < 4; i++) begin
      sdi[i] = (cnt_q < 24) ? word_q[i][23-cnt_q] : ~sdi[i];
    end
    cnt_q = cnt_q + 1;
  end
endmodule // converter_model

// >>> dv/analog_input_readout_tb_top.sv
// testbench: register access, filter outputs, sample conversion
`timescale 1ns/1ps
module analog_input_readout_tb_top;
  import readout_pkg::*;
  logic        clock, rst, wr_stb, rd_stb, phase_clk;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, v, gpio_out, gpio_oe;
  logic [3:0]  bus_bank, bank_sw, sdi_r, sdi_f;
  logic        sclk_r, sclk_f, stb_r, stb_f;
  logic [15:0] filter_sel;
  int          error_cnt, total_checks;
  logic [7:0]  ra [10] = '{8'h24, 8'h28, 8'h2c, 8'h30, 8'h34, 8'h38,
                           8'h3c, 8'h40, 8'h44, 8'h20};
  logic [31:0] rv [10] = '{32'h5, 32'hfffffc01, 0, 32'h1, 32'hfffffc,
                           0, 0, 32'hffff, 0, 0};
  logic [15:0] ex [8]  = '{16'h7f2e, 16'h80d2, 16'h0001, 16'hffff,
                           16'h1234, 16'hfedc, 16'h80d2, 16'h7f2e};

  analog_input_readout uut (.clock(clock), .rst(rst), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .bus_bank(bus_bank), .bank_switch(bank_sw), .phase_clk(phase_clk),
    .sdi_rise(sdi_r), .sdi_fall(sdi_f), .sclk_rise(sclk_r),
    .sclk_fall(sclk_f), .strobe_rise(stb_r), .strobe_fall(stb_f),
    .filter_sel(filter_sel), .gpio_out(gpio_out), .gpio_oe(gpio_oe));
  converter_model conv_r (.strobe(stb_r), .sclk(sclk_r), .sdi(sdi_r),
    .codes({16'hfedc, 16'h1234, 16'h8000, 16'h7fff}));
  converter_model conv_f (.strobe(stb_f), .sclk(sclk_f), .sdi(sdi_f),
    .codes({16'h7f2e, 16'h80d2, 16'hffff, 16'h0001}));

  // ----------------------------------------
  // bus tasks and comparison
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr   <= a;
    wdata  <= d;
    wr_stb <= 1'b1;
    @(posedge clock);
    wr_stb <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge clock);
    rd_stb <= 1'b0;
    @(posedge clock);
    d = rdata;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // input n sample register at byte address 4n
  task automatic chk_in(input int n, input logic [15:0] e);
    rd(8'(n * 4), v);
    chk(v, {e, 16'h0000});
  endtask

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  initial begin
    repeat (4000) @(posedge clock);
    error_cnt++;
    report_and_stop();
  end

  initial begin
    {rst, wr_stb, rd_stb, phase_clk} = 4'b1000;
    addr = 8'h00;
    wdata = 0;
    bus_bank = 4'h3;
    bank_sw = 4'h3;
    error_cnt = 0;
    total_checks = 0;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    for (int i = 0; i < 10; i++) begin
      rd(ra[i], v);
      chk(v, rv[i]);
    end
    chk(gpio_oe, 32'h0000ffff);
    chk({16'h0, filter_sel}, 0);
    rd(8'h48, v);
    chk({28'h0, v[11:8]}, 32'h3);
    rd(8'h80, v);
    chk(v, 0);
    for (int c = 0; c < 4; c++) begin
      wr(8'h20, {16'h0, {8{2'(c)}}});
      repeat (2) @(posedge clock);
      chk({16'h0, filter_sel}, {16'h0, {8{2'(c)}}});
      chk({30'h0, filter_sel[15:14]}, c);
    end
    wr(8'h20, 32'hffffc001);
    rd(8'h20, v);
    chk(v, 32'hffffc001);
    chk(gpio_out, 32'h0000c001);
    bus_bank <= 4'h2;
    wr(8'h20, 32'h0);
    rd(8'h20, v);
    chk(v, 0);
    bus_bank <= 4'h3;
    rd(8'h20, v);
    chk(v, 32'hffffc001);
    phase_clk <= 1'b1;
    repeat (300) @(posedge clock);
    for (int i = 0; i < 8; i++) begin
      chk_in(i, (i % 4 < 2) ? ex[i] : 16'h0);
    end
    phase_clk <= 1'b0;
    repeat (300) @(posedge clock);
    for (int i = 0; i < 8; i++) begin
      chk_in(i, ex[i]);
    end
    // divider 4 and offset-binary converters on the rising group
    wr(OFF_DIV, 32'h4);
    wr(OFF_UTOS, 32'h1);
    phase_clk <= 1'b1;
    repeat (300) @(posedge clock);
    chk_in(0, 16'hffff);
    chk_in(1, 16'h0000);
    chk_in(4, 16'h9234);
    chk_in(5, 16'h7edc);
    chk_in(2, ex[2]);
    // second reset with phase high and another switch position
    rst <= 1'b1;
    bank_sw <= 4'hc;
    bus_bank <= 4'hc;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    for (int i = 0; i < 10; i++) begin
      rd(ra[i], v);
      chk(v, rv[i]);
    end
    chk({16'h0, filter_sel}, 0);
    rd(8'h48, v);
    chk({28'h0, v[11:8]}, 32'hc);
    repeat (300) @(posedge clock);
    chk_in(0, 16'h0000);
    report_and_stop();
  end
endmodule // analog_input_readout_tb_top
